// ===== rtl/dbb_boot_sel.sv
/*
 * Dual-bank boot selector: strap and option sampling, boot space choice,
 * bank 2 / bank 1 stack-pointer check, loader interface activation.
 * Assumes a same-clock memory read port (req held until a one-cycle ack),
 * a serial unit that reports received bytes and auto-baud completion,
 * and strap and receive pins that are asynchronous to clk.
 * The memory port answers the option word first, then at most two bank
 * words; read data only matters in the cycle of the ack.
 * The serial unit flags one byte per pulse, tagged with its interface.
 * The SRAM bounds and the early-silicon flag are static while booting.
 * Straps are sampled once per reset; later strap changes are ignored.
 */
// What this block does
// - Flag set: primary low boots user flash, primary high with secondary low boots system memory, both high boots SRAM.
// - Flag clear and primary low boots system memory and runs the dual-bank check.
// - Flag clear with both straps high boots SRAM with no dual-bank check.
// - The check reads bank 2 first and jumps to bank 2 when its code is valid.
// - Otherwise bank 1 is read and jumped to when its code is valid.
// - With no valid bank there is no jump and the serial loader runs as for strapped system-memory boot.
// - A bank is valid only when its first word lies inside the internal SRAM range.
// - The bank-boot flag is bit 19 of the option word at 0x1FFFF800, and set disables the check.
// - With the flag set the dual-bank check never runs, whatever the straps.
// - The transmit pin is driven push-pull only after a correct 0x7F and with the serial unit clocked, floating before.
// - On early silicon, detection fails when any monitored receive line is low during activation.
// - After a correct 0x7F the loader runs auto-baud and then waits for commands on that interface.
`timescale 1ns/10ps
`default_nettype none

module dbb_boot_sel
    import dbb_pkg::*;
(
    // Clock, reset and pins
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              boot_strap_primary,
    input  wire logic              boot_strap_secondary,
    input  wire logic [N_IF-1:0]   rx_lines,
    // Static configuration
    input  wire logic              early_rev,
    input  wire logic [31:0]       sram_lo,
    input  wire logic [31:0]       sram_hi,
    // Memory read port
    output logic                   mem_req,
    output logic      [31:0]       mem_addr,
    input  wire logic              mem_ack,
    input  wire logic [31:0]       mem_rdata,
    // Serial unit
    input  wire logic              rx_byte_valid,
    input  wire logic [1:0]        rx_byte_if,
    input  wire logic [7:0]        rx_byte,
    input  wire logic              serial_clk_on,
    input  wire logic              autobaud_done,
    // Boot decision
    output logic      [1:0]        boot_space,
    output logic                   boot_done,
    output logic                   jump_req,
    output logic      [31:0]       jump_base,
    // Loader activation
    output logic                   loader_active,
    output logic      [1:0]        loader_if,
    output logic                   autobaud_start,
    output logic                   cmd_wait,
    output logic                   tx_oe,
    output logic                   detect_fail
);

    typedef struct packed {
        // Sequence state and settle counter
        dbb_state_t  st;
        logic [2:0]  cnt;
        // Latched straps and bank-boot flag
        logic        prim;
        logic        sec;
        logic        flag;
        // Decision outputs
        logic [1:0]  space;
        logic        done;
        // Memory request
        logic        req;
        logic [31:0] addr;
        // Jump request
        logic        jump;
        logic [31:0] jbase;
        // Loader activation
        logic        loader;
        logic        sync_seen;
        logic [1:0]  iface;
        logic        baud;
        logic        cmd;
        logic        tx_oe;
        logic        fail;
    } dbb_top_st_t;

    dbb_top_st_t st_q;
    dbb_top_st_t st_d;

    // Synchronised pins and bank verdict
    logic [N_IF+1:0] pins_sync;
    logic            strap_p;
    logic            strap_s;
    logic [N_IF-1:0] rx_sync;
    logic            bank_valid;

    // Pins pass two flops before any logic reads them
    dbb_sync2 #(
        .W       (N_IF + 2),
        .RST_VAL ({(N_IF + 2){1'b1}})
    ) u_pin_sync (
        .clk      (clk),
        .srst     (srst),
        .async_in ({boot_strap_primary, boot_strap_secondary, rx_lines}),
        .sync_out (pins_sync)
    );

    assign strap_p = pins_sync[N_IF+1];
    assign strap_s = pins_sync[N_IF];
    assign rx_sync = pins_sync[N_IF-1:0];

    // Range check on the word returned by memory
    dbb_sp_check u_sp_check (
        .word    (mem_rdata),
        .sram_lo (sram_lo),
        .sram_hi (sram_hi),
        .valid   (bank_valid)
    );

    // Boot sequence
    always_comb begin
        st_d      = st_q;
        st_d.baud = 1'b0;
        unique case (st_q.st)
            // Let the strap synchronisers settle, then latch straps
            ST_SETTLE: begin
                if (st_q.cnt == 3'h0) begin
                    st_d.prim = strap_p;
                    st_d.sec  = strap_s;
                    st_d.req  = 1'b1;
                    st_d.addr = OPT_WORD_ADDR;
                    st_d.st   = ST_OPT;
                end else begin
                    st_d.cnt = st_q.cnt - 3'h1;
                end
            end

            // Fetch the option word holding the bank-boot flag
            ST_OPT: begin
                if (mem_ack) begin
                    st_d.flag = mem_rdata[BANK_FLAG_BIT];
                    st_d.req  = 1'b0;
                    st_d.st   = ST_DECIDE;
                end
            end

            // Choose boot space from flag and straps
            // Straps first; the flag only counts with primary low
            ST_DECIDE: begin
                st_d.done = 1'b1;
                if (st_q.prim && st_q.sec) begin
                    st_d.space = SPACE_SRAM;
                    st_d.st    = ST_IDLE;
                end else if (st_q.prim) begin
                    st_d.space  = SPACE_SYSMEM;
                    st_d.loader = 1'b1;
                    st_d.st     = ST_DETECT;
                end else if (st_q.flag) begin
                    st_d.space = SPACE_FLASH;
                    st_d.st    = ST_IDLE;
                end else begin
                    st_d.space = SPACE_SYSMEM;
                    st_d.done  = 1'b0;
                    st_d.req   = 1'b1;
                    st_d.addr  = BANK2_BASE;
                    st_d.st    = ST_BANK2;
                end
            end

            // Bank 2 is judged first
            ST_BANK2: begin
                if (mem_ack) begin
                    if (bank_valid) begin
                        st_d.req   = 1'b0;
                        st_d.jbase = BANK2_BASE;
                        st_d.st    = ST_JUMP;
                    end else begin
                        st_d.addr = BANK1_BASE;
                        st_d.st   = ST_BANK1;
                    end
                end
            end

            // Then bank 1
            ST_BANK1: begin
                if (mem_ack) begin
                    st_d.req = 1'b0;
                    if (bank_valid) begin
                        st_d.jbase = BANK1_BASE;
                        st_d.st    = ST_JUMP;
                    end else begin
                        st_d.done   = 1'b1;
                        st_d.loader = 1'b1;
                        st_d.st     = ST_DETECT;
                    end
                end
            end

            // Leave the loader and start from the chosen bank
            ST_JUMP: begin
                st_d.jump = 1'b1;
                st_d.done = 1'b1;
                st_d.st   = ST_IDLE;
            end

            // Interface activation: watch for the sync byte
            // On early silicon a low line wins over a same-cycle sync byte
            ST_DETECT: begin
                if (early_rev && (rx_sync != {N_IF{1'b1}})) begin
                    st_d.fail   = 1'b1;
                    st_d.loader = 1'b0;
                    st_d.st     = ST_IDLE;
                end else if (rx_byte_valid && (rx_byte == SYNC_BYTE)) begin
                    st_d.sync_seen = 1'b1;
                    st_d.iface     = rx_byte_if;
                    st_d.baud      = 1'b1;
                    st_d.st        = ST_BAUD;
                end
            end

            // Auto-baud running on the chosen interface
            ST_BAUD: begin
                if (autobaud_done) begin
                    st_d.cmd = 1'b1;
                    st_d.st  = ST_CMD;
                end
            end

            // Waiting for loader commands; other interfaces ignored
            ST_CMD: begin
                st_d.cmd = 1'b1;
            end

            // Parked: flash, SRAM, jump taken or detection failed
            ST_IDLE: begin
                st_d.req = 1'b0;
            end

            // Illegal code: park
            default: begin
                st_d.st = ST_IDLE;
            end
        endcase

        // Transmit pin driven only after sync and with serial clock on
        st_d.tx_oe = st_q.sync_seen && serial_clk_on;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.st        <= ST_SETTLE;
            st_q.cnt       <= SETTLE_CNT_INIT;
            st_q.prim      <= 1'b0;
            st_q.sec       <= 1'b0;
            // Flag reads as set until the option word arrives
            st_q.flag      <= 1'b1;
            st_q.space     <= SPACE_NONE;
            st_q.done      <= 1'b0;
            st_q.req       <= 1'b0;
            st_q.addr      <= RST_WORD;
            st_q.jump      <= 1'b0;
            st_q.jbase     <= RST_WORD;
            st_q.loader    <= 1'b0;
            st_q.sync_seen <= 1'b0;
            st_q.iface     <= 2'h0;
            st_q.baud      <= 1'b0;
            st_q.cmd       <= 1'b0;
            st_q.tx_oe     <= 1'b0;
            st_q.fail      <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // Memory port straight from the state register
    assign mem_req        = st_q.req;
    assign mem_addr       = st_q.addr;

    // Decision and jump
    assign boot_space     = st_q.space;
    assign boot_done      = st_q.done;
    assign jump_req       = st_q.jump;
    assign jump_base      = st_q.jbase;

    // Loader activation and transmit pin
    assign loader_active  = st_q.loader;
    assign loader_if      = st_q.iface;
    assign autobaud_start = st_q.baud;
    assign cmd_wait       = st_q.cmd;
    assign tx_oe          = st_q.tx_oe;
    assign detect_fail    = st_q.fail;

endmodule

`default_nettype wire

// ===== pkg/dbb_pkg.sv
/*
 * Constants and types shared by the dual-bank boot selector.
 * Assumes a single 200 MHz clock and a 32-bit word read port to memory.
 */
package dbb_pkg;

    // Clock and strap settling time
    localparam int unsigned CLK_PERIOD_PS    = 5000;
    localparam int unsigned STRAP_SETTLE_NS  = 20;
    localparam int unsigned STRAP_SETTLE_CYC =
        (STRAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0]  SETTLE_CNT_INIT  = 3'(STRAP_SETTLE_CYC);

    // Option word and bank bases
    localparam logic [31:0] OPT_WORD_ADDR   = 32'h1FFF_F800;
    localparam int unsigned BANK_FLAG_BIT   = 19;
    localparam logic [31:0] BANK1_BASE      = 32'h0800_0000;
    localparam logic [31:0] BANK2_BASE      = 32'h0808_0000;

    // Serial sync byte
    localparam logic [7:0]  SYNC_BYTE       = 8'h7F;

    // Number of monitored loader receive lines
    localparam int unsigned N_IF            = 4;

    // Boot space codes
    localparam logic [1:0]  SPACE_NONE      = 2'h0;
    localparam logic [1:0]  SPACE_FLASH     = 2'h1;
    localparam logic [1:0]  SPACE_SYSMEM    = 2'h2;
    localparam logic [1:0]  SPACE_SRAM      = 2'h3;

    // Reset values
    localparam logic [31:0] RST_WORD        = 32'h0000_0000;

    typedef enum logic [9:0] {
        ST_SETTLE = 10'h001,
        ST_OPT    = 10'h002,
        ST_DECIDE = 10'h004,
        ST_BANK2  = 10'h008,
        ST_BANK1  = 10'h010,
        ST_JUMP   = 10'h020,
        ST_DETECT = 10'h040,
        ST_BAUD   = 10'h080,
        ST_CMD    = 10'h100,
        ST_IDLE   = 10'h200
    } dbb_state_t;

endpackage

// ===== rtl/dbb_sync2.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous to clk; only the second stage is read.
 */
`timescale 1ns/10ps
`default_nettype none

module dbb_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dbb_sync_st_t;

    dbb_sync_st_t st_q;
    dbb_sync_st_t st_d;

    // Shift chain
    always_comb begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.s1 <= RST_VAL;
            st_q.s2 <= RST_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign sync_out = st_q.s2;

endmodule

`default_nettype wire

// ===== rtl/dbb_sp_check.sv
/*
 * Stack-pointer range check for one bank's first word.
 * Assumes bounds are stable while a bank word is being judged.
 */
`timescale 1ns/10ps
`default_nettype none

module dbb_sp_check (
    input  wire logic [31:0] word,
    input  wire logic [31:0] sram_lo,
    input  wire logic [31:0] sram_hi,
    output logic             valid
);

    // Valid only inside the fitted SRAM window
    always_comb begin
        valid = (word >= sram_lo) && (word <= sram_hi);
    end

endmodule

`default_nettype wire

// ===== test/dbb_boot_sel_sva.sv
/* Port assertions for the dual-bank boot selector.
   Bound into every dbb_boot_sel instance; one clock, reset srst. */
`timescale 1ns/10ps
`default_nettype none
module dbb_boot_sel_sva
    import dbb_pkg::*;
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [31:0] sram_lo,
    input wire logic [31:0] sram_hi,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic        rx_byte_valid,
    input wire logic [7:0]  rx_byte,
    input wire logic        serial_clk_on,
    input wire logic        jump_req,
    input wire logic [31:0] jump_base,
    input wire logic        loader_active,
    input wire logic        autobaud_start,
    input wire logic        tx_oe,
    input wire logic        detect_fail
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic flag_q;
    // Bank flag as last read from the option word
    always_ff @(posedge clk) begin
        if (srst) begin
            flag_q <= 1'b1;
        end else if (mem_req && mem_ack && mem_addr == OPT_WORD_ADDR) begin
            flag_q <= mem_rdata[BANK_FLAG_BIT];
        end
    end
    // Accepted bank word read with its range verdict
    sequence s_rd(logic [31:0] a, logic v);
        mem_req && mem_ack && mem_addr == a
            && ((mem_rdata >= sram_lo && mem_rdata <= sram_hi) == v);
    endsequence
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr)) else $error("request not held");
    AST_FLAG_GATE: assert property (
        mem_req && mem_addr == BANK2_BASE |-> !flag_q)
        else $error("bank check with flag set");
    AST_B2_JUMP: assert property (
        s_rd(BANK2_BASE, 1'b1) |-> ##[1:4] (jump_req
        && jump_base == BANK2_BASE)) else $error("no jump to bank 2");
    AST_B1_NEXT: assert property (
        s_rd(BANK2_BASE, 1'b0) |=> mem_req && mem_addr == BANK1_BASE)
        else $error("bank 1 not read next");
    AST_B1_JUMP: assert property (
        s_rd(BANK1_BASE, 1'b1) |-> ##[1:4] (jump_req
        && jump_base == BANK1_BASE)) else $error("no jump to bank 1");
    AST_NO_JUMP: assert property (
        s_rd(BANK1_BASE, 1'b0) |-> ##[1:4] (loader_active && !jump_req))
        else $error("loader not started");
    AST_TX_OE: assert property (tx_oe |-> $past(serial_clk_on))
        else $error("transmit driven while unclocked");
    AST_SYNC: assert property (autobaud_start |->
        $past(rx_byte_valid) && $past(rx_byte) == SYNC_BYTE)
        else $error("auto-baud without sync");
    AST_DETECT: assert property (detect_fail |-> !loader_active)
        else $error("loader active after failed detection");
endmodule
bind dbb_boot_sel dbb_boot_sel_sva u_sva (.clk(clk), .srst(srst),
    .sram_lo(sram_lo), .sram_hi(sram_hi), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .serial_clk_on(serial_clk_on), .jump_req(jump_req),
    .jump_base(jump_base), .loader_active(loader_active),
    .autobaud_start(autobaud_start), .tx_oe(tx_oe),
    .detect_fail(detect_fail));
`default_nettype wire

// ===== test/dbb_mem_model.sv
/* Memory read port model holding the option word and both bank words.
   Assumes requests held until the one-cycle ack, as the selector does. */
`timescale 1ns/10ps
`default_nettype none
module dbb_mem_model
    import dbb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic      [31:0] mem_rdata,
    input  wire logic [31:0] opt_word,
    input  wire logic [31:0] bank2_word,
    input  wire logic [31:0] bank1_word,
    input  wire logic        slow
);
    logic [1:0] wait_q;
    // Word stored at each mapped address
    function automatic logic [31:0] word_at(input logic [31:0] a);
        if (a == OPT_WORD_ADDR) return opt_word;
        if (a == BANK2_BASE) return bank2_word;
        if (a == BANK1_BASE) return bank1_word;
        return ~a;
    endfunction
    // Answer after zero or two idle cycles; data junk outside the ack
    always_ff @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (srst) begin
            wait_q <= 2'h0;
            mem_rdata <= 32'h5A5A_5A5A;
        end else if (mem_req && !mem_ack) begin
            if (wait_q == (slow ? 2'h2 : 2'h0)) begin
                mem_ack <= 1'b1;
                wait_q <= 2'h0;
                mem_rdata <= word_at(mem_addr);
            end else begin
                wait_q <= wait_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/testbench.sv
/* Self-checking bench for the boot selector with a memory model.
   Assumes a 200 MHz clock; inputs change on the falling edge. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dbb_pkg::*;
    logic clk = 0, srst = 1, bp = 0, bs = 0, early = 0, slow = 0;
    logic rxv = 0, sclk_on = 0, ab_done = 0;
    logic [3:0] rxl = 4'hF;
    logic [7:0] rxb = 8'h00;
    logic [1:0] rif = 2'h0;
    logic [31:0] opt = 32'h0, w2 = 32'h0, w1 = 32'h0;
    logic [31:0] lo = 32'h2000_0000, hi = 32'h2001_7FFF;
    logic mreq, mack, jreq, ldr, abs, cw, txoe, dfail, bdone;
    logic [31:0] maddr, mrd, jbase;
    logic [1:0] sp, lif;
    int fail_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    dbb_boot_sel dut (.clk(clk), .srst(srst), .boot_strap_primary(bp),
        .boot_strap_secondary(bs), .rx_lines(rxl), .early_rev(early),
        .sram_lo(lo), .sram_hi(hi), .mem_req(mreq), .mem_addr(maddr),
        .mem_ack(mack), .mem_rdata(mrd), .rx_byte_valid(rxv),
        .rx_byte_if(rif), .rx_byte(rxb), .serial_clk_on(sclk_on),
        .autobaud_done(ab_done), .boot_space(sp), .boot_done(bdone),
        .jump_req(jreq), .jump_base(jbase), .loader_active(ldr),
        .loader_if(lif), .autobaud_start(abs), .cmd_wait(cw),
        .tx_oe(txoe), .detect_fail(dfail));
    dbb_mem_model u_mem (.clk(clk), .srst(srst), .mem_req(mreq),
        .mem_addr(maddr), .mem_ack(mack), .mem_rdata(mrd), .opt_word(opt),
        .bank2_word(w2), .bank1_word(w1), .slow(slow));
    task check_bit(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: bit %b not %b", $time, g, e);
        end
    endtask
    task check_code(input logic [1:0] g, input logic [1:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: code %h not %h", $time, g, e);
        end
    endtask
    task check_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: word %h not %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Reset with given straps, flag and bank words; wait for the decision
    task boot(input logic p, s, f, input logic [31:0] a, b);
        int i;
        @(negedge clk);
        srst = 1;
        bp = p;
        bs = s;
        opt = {12'hFFF, f, 19'h7FFFF};
        w2 = a;
        w1 = b;
        repeat (8) @(negedge clk);
        srst = 0;
        for (i = 0; i < 100 && bdone !== 1'b1; i++) @(negedge clk);
        check_bit(bdone, 1);
        repeat (3) @(negedge clk);
    endtask
    task t_flag_set;
        boot(0, 1, 1, hi, lo);
        check_code(sp, SPACE_FLASH);
        check_bit(jreq, 0);
        boot(1, 0, 1, lo, lo);
        check_code(sp, SPACE_SYSMEM);
        check_bit(ldr, 1);
        boot(1, 1, 1, lo, lo);
        check_code(sp, SPACE_SRAM);
        $display("flag set test done");
    endtask
    task t_sram;
        boot(1, 1, 0, lo, lo);
        check_code(sp, SPACE_SRAM);
        check_bit(jreq, 0);
        $display("sram test done");
    endtask
    task t_banks;
        slow = 1;
        boot(0, 1, 0, hi, lo);
        check_code(sp, SPACE_SYSMEM);
        check_word(jbase, BANK2_BASE);
        slow = 0;
        boot(0, 0, 0, hi + 32'h1, lo);
        check_bit(jreq, 1);
        check_word(jbase, BANK1_BASE);
        boot(0, 0, 0, lo - 32'h1, hi);
        check_word(jbase, BANK1_BASE);
        $display("bank test done");
    endtask
    // No valid bank, then sync, auto-baud and transmit enable
    task t_loader;
        int i;
        boot(0, 0, 0, 32'h0, 32'h0);
        check_bit(jreq, 0);
        check_bit(ldr, 1);
        check_bit(txoe, 0);
        rxl = 4'h0;
        sclk_on = 1;
        rxv = 1;
        rxb = 8'h55;
        rif = 2'h3;
        @(negedge clk);
        rxb = SYNC_BYTE;
        rif = 2'h2;
        @(negedge clk);
        rxv = 0;
        for (i = 0; i < 4 && abs !== 1'b1; i++) @(negedge clk);
        check_bit(abs, 1);
        check_code(lif, 2'h2);
        repeat (2) @(negedge clk);
        check_bit(abs, 0);
        check_bit(txoe, 1);
        check_bit(dfail, 0);
        sclk_on = 0;
        repeat (3) @(negedge clk);
        check_bit(txoe, 0);
        ab_done = 1;
        @(negedge clk);
        ab_done = 0;
        repeat (2) @(negedge clk);
        check_bit(cw, 1);
        rxv = 1;
        rif = 2'h1;
        @(negedge clk);
        rxv = 0;
        check_bit(abs, 0);
        check_code(lif, 2'h2);
        rxl = 4'hF;
        $display("loader test done");
    endtask
    task t_detect;
        early = 1;
        boot(1, 0, 1, 32'h0, 32'h0);
        check_bit(ldr, 1);
        check_bit(dfail, 0);
        rxl = 4'hE;
        repeat (6) @(negedge clk);
        check_bit(dfail, 1);
        check_bit(ldr, 0);
        rxv = 1;
        @(negedge clk);
        rxv = 0;
        check_bit(abs, 0);
        rxl = 4'hF;
        early = 0;
        $display("detect test done");
    endtask
    // Main sequence
    initial begin
        t_flag_set();
        t_sram();
        t_banks();
        t_loader();
        t_detect();
        test_done();
    end
    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        test_done();
    end
endmodule
`default_nettype wire
